// ### xzf_fifo.sv
// Synchronous FIFO with valid and ready on both sides, used in the byte path of the framer.
// Assumes a single clock and a synchronous active-high reset; DEPTH must be a power of two.

module xzf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } xzf_fifo_state_t;

  xzf_fifo_state_t st_reg;
  xzf_fifo_state_t st_next;
  logic            push;
  logic            pop;

  // Full and empty come from the count, so neither can lie on a wrap.
  assign in_ready  = (st_reg.count != (AW + 1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data  = st_reg.mem[st_reg.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr             = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ### xzf_framer.sv
// Package of constants and the host-side framer that builds explicit transmit frames
// carrying a cluster-library Read Attributes command, byte by byte, into a FIFO.
// Assumes the byte sink on out_data follows valid/ready and that requests come
// from logic on the same clock.

package xzf_pkg;

  // ---------------------------------------------------------------
  // Frame constants
  // ---------------------------------------------------------------
  localparam logic [7:0]  SOF_BYTE     = 8'h7e;
  localparam logic [7:0]  FRAME_TYPE   = 8'h11;
  localparam logic [63:0] BCAST_LONG   = 64'h0000_0000_0000_ffff;
  localparam logic [15:0] SHORT_UNK    = 16'hfffe;
  localparam logic [7:0]  TX_OPTIONS   = 8'h00;
  localparam logic [7:0]  FRAME_CTRL   = 8'h00;
  localparam logic [7:0]  CMD_READ     = 8'h00;
  localparam logic [7:0]  CSUM_BASE    = 8'hff;
  localparam int          ATTR_MAX     = 4;
  localparam logic [15:0] FIXED_LEN    = 16'h0017;

  // ---------------------------------------------------------------
  // Byte offsets within the frame
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_SOF      = 6'h00;
  localparam logic [5:0] OFS_LEN_HI   = 6'h01;
  localparam logic [5:0] OFS_LEN_LO   = 6'h02;
  localparam logic [5:0] OFS_TYPE     = 6'h03;
  localparam logic [5:0] OFS_ID       = 6'h04;
  localparam logic [5:0] OFS_LONG_HI  = 6'h05;
  localparam logic [5:0] OFS_LONG_LO  = 6'h0c;
  localparam logic [5:0] OFS_SHORT_HI = 6'h0d;
  localparam logic [5:0] OFS_SHORT_LO = 6'h0e;
  localparam logic [5:0] OFS_SRC_EP   = 6'h0f;
  localparam logic [5:0] OFS_DST_EP   = 6'h10;
  localparam logic [5:0] OFS_CLUS_HI  = 6'h11;
  localparam logic [5:0] OFS_CLUS_LO  = 6'h12;
  localparam logic [5:0] OFS_PROF_HI  = 6'h13;
  localparam logic [5:0] OFS_PROF_LO  = 6'h14;
  localparam logic [5:0] OFS_RADIUS   = 6'h15;
  localparam logic [5:0] OFS_OPTIONS  = 6'h16;
  localparam logic [5:0] OFS_FCTRL    = 6'h17;
  localparam logic [5:0] OFS_SEQ      = 6'h18;
  localparam logic [5:0] OFS_CMD      = 6'h19;
  localparam logic [5:0] OFS_ATTR     = 6'h1a;

  localparam int FIFO_DEPTH = 16;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                 frame_id;
    logic [63:0]                dest_long;
    logic [15:0]                dest_short;
    logic                       broadcast;
    logic                       short_unknown;
    logic [7:0]                 src_ep;
    logic [7:0]                 dst_ep;
    logic [15:0]                cluster;
    logic [15:0]                profile;
    logic [7:0]                 radius;
    logic [7:0]                 seq;
    logic [2:0]                 attr_count;
    logic [ATTR_MAX-1:0][15:0]  attr;
  } xzf_req_t;

  typedef enum logic [0:0] {
    XZF_IDLE,
    XZF_SEND
  } xzf_state_t;

endpackage

module xzf_framer (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire xzf_pkg::xzf_req_t req,
  input  wire logic          req_valid,
  output logic               req_ready,
  output logic [7:0]         out_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic               busy
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    xzf_pkg::xzf_state_t fsm;
    xzf_pkg::xzf_req_t   rq;
    logic [5:0]          idx;
    logic [7:0]          sum;
    logic                req_ready;
    logic                busy;
    logic [7:0]          out_data;
    logic                out_valid;
  } xzf_top_state_t;

  xzf_top_state_t st_reg;
  xzf_top_state_t st_next;

  logic [7:0]  cur_byte;
  logic [15:0] frame_len;
  logic [5:0]  last_idx;
  logic [5:0]  long_sel;
  logic [5:0]  attr_sel;
  logic        push;
  logic        fifo_in_ready;
  logic [7:0]  fifo_out_data;
  logic        fifo_out_valid;
  logic        fifo_out_ready;

  // Length counts frame data from the type byte to the last attribute.
  assign frame_len = xzf_pkg::FIXED_LEN + {12'h000, st_reg.rq.attr_count, 1'b0};
  assign last_idx  = xzf_pkg::OFS_ATTR + {2'b00, st_reg.rq.attr_count, 1'b0};
  assign long_sel  = xzf_pkg::OFS_LONG_LO - st_reg.idx;
  assign attr_sel  = st_reg.idx - xzf_pkg::OFS_ATTR;
  assign push      = (st_reg.fsm == xzf_pkg::XZF_SEND);

  // ---------------------------------------------------------------
  // Byte selection
  // ---------------------------------------------------------------
  always_comb begin
    cur_byte = 8'h00;
    if (st_reg.idx == last_idx) begin
      cur_byte = xzf_pkg::CSUM_BASE - st_reg.sum;
    end else if (st_reg.idx >= xzf_pkg::OFS_ATTR) begin
      // Attribute identifiers go out low byte first.
      cur_byte = attr_sel[0] ? st_reg.rq.attr[attr_sel[2:1]][15:8]
                             : st_reg.rq.attr[attr_sel[2:1]][7:0];
    end else if (st_reg.idx >= xzf_pkg::OFS_LONG_HI && st_reg.idx <= xzf_pkg::OFS_LONG_LO) begin
      cur_byte = st_reg.rq.dest_long[{long_sel[2:0], 3'b000} +: 8];
    end else begin
      case (st_reg.idx)
        xzf_pkg::OFS_SOF:      cur_byte = xzf_pkg::SOF_BYTE;
        xzf_pkg::OFS_LEN_HI:   cur_byte = frame_len[15:8];
        xzf_pkg::OFS_LEN_LO:   cur_byte = frame_len[7:0];
        xzf_pkg::OFS_TYPE:     cur_byte = xzf_pkg::FRAME_TYPE;
        xzf_pkg::OFS_ID:       cur_byte = st_reg.rq.frame_id;
        xzf_pkg::OFS_SHORT_HI: cur_byte = st_reg.rq.dest_short[15:8];
        xzf_pkg::OFS_SHORT_LO: cur_byte = st_reg.rq.dest_short[7:0];
        xzf_pkg::OFS_SRC_EP:   cur_byte = st_reg.rq.src_ep;
        xzf_pkg::OFS_DST_EP:   cur_byte = st_reg.rq.dst_ep;
        xzf_pkg::OFS_CLUS_HI:  cur_byte = st_reg.rq.cluster[15:8];
        xzf_pkg::OFS_CLUS_LO:  cur_byte = st_reg.rq.cluster[7:0];
        xzf_pkg::OFS_PROF_HI:  cur_byte = st_reg.rq.profile[15:8];
        xzf_pkg::OFS_PROF_LO:  cur_byte = st_reg.rq.profile[7:0];
        // Zero is passed through untouched; the module reads it as maximum hops.
        xzf_pkg::OFS_RADIUS:   cur_byte = st_reg.rq.radius;
        xzf_pkg::OFS_OPTIONS:  cur_byte = xzf_pkg::TX_OPTIONS;
        xzf_pkg::OFS_FCTRL:    cur_byte = xzf_pkg::FRAME_CTRL;
        xzf_pkg::OFS_SEQ:      cur_byte = st_reg.rq.seq;
        xzf_pkg::OFS_CMD:      cur_byte = xzf_pkg::CMD_READ;
        default:               cur_byte = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    case (st_reg.fsm)
      xzf_pkg::XZF_IDLE: begin
        if (req_valid && st_reg.req_ready) begin
          st_next.rq  = req;
          st_next.idx = xzf_pkg::OFS_SOF;
          st_next.sum = 8'h00;
          if (req.attr_count > 3'(xzf_pkg::ATTR_MAX)) begin
            st_next.rq.attr_count = 3'(xzf_pkg::ATTR_MAX);
          end
          if (req.broadcast) begin
            st_next.rq.dest_long  = xzf_pkg::BCAST_LONG;
            st_next.rq.dest_short = xzf_pkg::SHORT_UNK;
          end else if (req.short_unknown) begin
            st_next.rq.dest_short = xzf_pkg::SHORT_UNK;
          end
          st_next.fsm       = xzf_pkg::XZF_SEND;
          st_next.req_ready = 1'b0;
          st_next.busy      = 1'b1;
        end
      end
      xzf_pkg::XZF_SEND: begin
        // A full FIFO holds the index, so no byte is skipped under back-pressure.
        if (fifo_in_ready) begin
          if (st_reg.idx >= xzf_pkg::OFS_TYPE) begin
            st_next.sum = st_reg.sum + cur_byte;
          end
          if (st_reg.idx == last_idx) begin
            st_next.fsm       = xzf_pkg::XZF_IDLE;
            st_next.req_ready = 1'b1;
            st_next.busy      = 1'b0;
          end else begin
            st_next.idx = st_reg.idx + 6'h01;
          end
        end
      end
      default: begin
        st_next.fsm       = xzf_pkg::XZF_IDLE;
        st_next.req_ready = 1'b1;
        st_next.busy      = 1'b0;
      end
    endcase
    if (!st_reg.out_valid || out_ready) begin
      st_next.out_valid = fifo_out_valid;
      st_next.out_data  = fifo_out_data;
    end
  end

  assign fifo_out_ready = !st_reg.out_valid || out_ready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg           <= '0;
      st_reg.fsm       <= xzf_pkg::XZF_IDLE;
      st_reg.req_ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign req_ready = st_reg.req_ready;
  assign busy      = st_reg.busy;
  assign out_valid = st_reg.out_valid;
  assign out_data  = st_reg.out_data;

  // ---------------------------------------------------------------
  // Byte FIFO
  // ---------------------------------------------------------------
  xzf_fifo #(
    .WIDTH (8),
    .DEPTH (xzf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (cur_byte),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Independent running sum of accepted bytes from the type byte on.
  logic [7:0] chk_sum_reg;
  always_ff @(posedge clk) begin
    if (sys_rst || !push) begin
      chk_sum_reg <= 8'h00;
    end else if (fifo_in_ready && st_reg.idx >= xzf_pkg::OFS_TYPE) begin
      chk_sum_reg <= chk_sum_reg + cur_byte;
    end
  end

  start_delim_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && st_reg.idx == 6'h00 |-> cur_byte == 8'h7e)
    else $error("start byte wrong");

  length_lo_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && st_reg.idx == 6'h02 |-> cur_byte == 8'd23 + {4'h0, st_reg.rq.attr_count, 1'b0})
    else $error("length byte wrong");

  frame_type_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && st_reg.idx == 6'h03 |-> cur_byte == 8'h11)
    else $error("frame type wrong");

  long_order_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && st_reg.idx == 6'h05 |-> cur_byte == st_reg.rq.dest_long[63:56])
    else $error("long address order wrong");

  bcast_long_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && st_reg.rq.broadcast && st_reg.idx == 6'h0b |-> cur_byte == 8'hff)
    else $error("broadcast address wrong");

  short_unknown_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && (st_reg.rq.broadcast || st_reg.rq.short_unknown) && st_reg.idx == 6'h0e
    |-> cur_byte == 8'hfe)
    else $error("short address wrong");

  options_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && (st_reg.idx == 6'h16 || st_reg.idx == 6'h17 || st_reg.idx == 6'h19)
    |-> cur_byte == 8'h00)
    else $error("fixed zero byte wrong");

  attr_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && st_reg.rq.attr_count != 3'h0 && st_reg.idx == 6'h1a
    |-> cur_byte == st_reg.rq.attr[0][7:0])
    else $error("attribute byte order wrong");

  frame_checksum_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && st_reg.idx == last_idx |-> 8'(chk_sum_reg + cur_byte) == 8'hff)
    else $error("checksum wrong");

  stall_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && !fifo_in_ready |=> push && $stable(st_reg.idx))
    else $error("byte lost under stall");

endmodule

// ### xzf_radio_model.sv
// Behavioural model of the radio module that receives framed bytes from the framer.
// Assumes one clock with a synchronous active-high reset; pace selects how it accepts bytes.

module xzf_radio_model #(
  parameter logic [7:0] MAX_HOPS = 8'h0a
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  output logic            rx_ready,
  input  wire logic [1:0] pace
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Frame capture
  // ---------------------------------------------------------------
  logic [7:0]  fbuf [0:63];
  int          idx;
  int          frames;
  logic [31:0] rng = 32'd74978;
  logic [7:0]  stream_q [$];
  logic        status_q [$];
  logic [7:0]  hops_q [$];
  logic [7:0]  echo_q [$];

  // Pace 1 drops ready on random cycles, pace 2 holds it low so the framer's buffer fills.
  always @(posedge clk) begin
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    if (sys_rst) begin
      idx = 0;
      frames = 0;
      rx_ready <= 1'b0;
    end else begin
      if (rx_valid && rx_ready) begin
        stream_q.push_back(rx_data);
        fbuf[idx] = rx_data;
        if (idx != 0 || rx_data == 8'h7e) idx++;
        if (idx > 3 && idx == int'({fbuf[1], fbuf[2]}) + 4) begin
          status_q.push_back(fbuf[4] != 8'h00);
          hops_q.push_back((fbuf[21] == 8'h00) ? MAX_HOPS : fbuf[21]);
          echo_q.push_back(fbuf[24]);
          frames++;
          idx = 0;
        end
      end
      rx_ready <= (pace == 2'd0) || (pace == 2'd1 && rng[3:2] != 2'b00);
    end
  end
endmodule

// ### tb_xzf_framer.sv
// Self-checking testbench of the explicit frame builder against the radio model.
// Assumes the framer holds its byte buffer inside and follows its valid/ready contract.

module tb_xzf_framer;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] NET_HOPS = 8'h0a;

  logic              clk;
  logic              sys_rst;
  xzf_pkg::xzf_req_t req;
  logic              req_valid;
  logic              req_ready;
  logic [7:0]        out_data;
  logic              out_valid;
  logic              out_ready;
  logic              busy;
  logic [1:0]        pace;
  logic [31:0]       seed;
  int                mismatches;
  int                compares;
  int                done_frames;
  xzf_pkg::xzf_req_t pend_q [$];

  xzf_framer uut (.clk(clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .busy(busy));

  xzf_radio_model #(.MAX_HOPS(NET_HOPS)) far_end (.clk(clk), .sys_rst(sys_rst),
    .rx_data(out_data), .rx_valid(out_valid), .rx_ready(out_ready), .pace(pace));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic xzf_pkg::xzf_req_t rand_req();
    logic [223:0]      w;
    xzf_pkg::xzf_req_t r;
    for (int i = 0; i < 7; i++) begin
      seed = xorshift(seed);
      w[32*i +: 32] = seed;
    end
    r = xzf_pkg::xzf_req_t'(w[220:0]);
    r.attr_count = w[2:0] % 3'd5;
    return r;
  endfunction

  function automatic logic [63:0] pick(input logic [7:0] g [$], input int at, input int cnt);
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < cnt; i++) v = {v[55:0], g[at + i]};
    return v;
  endfunction

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A cycle passes before raising valid, so a back-to-back call never drives it twice at once.
  task automatic send(input xzf_pkg::xzf_req_t r);
    int k;
    k = 0;
    @(negedge clk);
    req = r;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    check("busy_after_take", busy, 64'h1);
    pend_q.push_back(r);
  endtask

  task automatic check_frame();
    xzf_pkg::xzf_req_t r;
    logic [7:0]        g [$];
    logic [63:0]       lng;
    logic [15:0]       sht;
    logic [7:0]        sum;
    int                n;
    int                k;
    r = pend_q.pop_front();
    n = int'(r.attr_count);
    k = 0;
    while (far_end.frames <= done_frames && k < 3000) begin
      @(negedge clk);
      k++;
    end
    done_frames++;
    check("frame_arrived", 64'(k < 3000), 64'h1);
    if (k >= 3000) return;
    // One frame is 27 bytes plus two per attribute; taking more would steal the next frame.
    repeat (27 + 2 * n) g.push_back(far_end.stream_q.pop_front());
    lng = r.broadcast ? 64'h0000_0000_0000_ffff : r.dest_long;
    sht = (r.broadcast || r.short_unknown) ? 16'hfffe : r.dest_short;
    sum = 8'h11 + r.frame_id + sht[15:8] + sht[7:0] + r.src_ep + r.dst_ep + r.cluster[15:8]
      + r.cluster[7:0] + r.profile[15:8] + r.profile[7:0] + r.radius + r.seq;
    for (int i = 0; i < 8; i++) sum += lng[8*i +: 8];
    for (int i = 0; i < n; i++) sum += r.attr[i][15:8] + r.attr[i][7:0];
    check("start", pick(g, 0, 1), 64'h7e);
    check("length", pick(g, 1, 2), 64'(16'h0017 + 16'(2 * n)));
    check("frame_type", pick(g, 3, 1), 64'h11);
    check("frame_id", pick(g, 4, 1), 64'(r.frame_id));
    check("long_addr", pick(g, 5, 8), lng);
    check("short_addr", pick(g, 13, 2), 64'(sht));
    check("endpoints", pick(g, 15, 2), 64'({r.src_ep, r.dst_ep}));
    check("cluster", pick(g, 17, 2), 64'(r.cluster));
    check("profile", pick(g, 19, 2), 64'(r.profile));
    check("radius", pick(g, 21, 1), 64'(r.radius));
    check("options", pick(g, 22, 1), 64'h0);
    check("frame_ctrl", pick(g, 23, 1), 64'h0);
    check("sequence", pick(g, 24, 1), 64'(r.seq));
    check("command", pick(g, 25, 1), 64'h0);
    for (int i = 0; i < n; i++) begin
      check("attr_id", pick(g, 26 + 2 * i, 2),
        64'({r.attr[i][7:0], r.attr[i][15:8]}));
    end
    check("checksum", pick(g, 26 + 2 * n, 1), 64'(8'hff - sum));
    check("status_sent", 64'(far_end.status_q.pop_front()),
      64'(r.frame_id != 8'h00));
    check("hops", 64'(far_end.hops_q.pop_front()),
      64'((r.radius == 8'h00) ? NET_HOPS : r.radius));
    check("echo", 64'(far_end.echo_q.pop_front()), 64'(r.seq));
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #(60000 * 100);
    mismatches++;
    conclude();
  end

  initial begin
    xzf_pkg::xzf_req_t r;
    sys_rst = 1'b1;
    req = '0;
    req_valid = 1'b0;
    pace = 2'd0;
    seed = 32'd74978;
    mismatches = 0;
    compares = 0;
    done_frames = 0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    check("idle_ready", 64'(req_ready), 64'h1);
    check("idle_busy", 64'(busy), 64'h0);
    for (int c = 0; c < 4; c++) begin
      r = rand_req();
      r.broadcast = (c == 0);
      r.short_unknown = (c == 1);
      r.attr_count = (c == 1) ? 3'd0 : ((c == 2) ? 3'd4 : 3'd1);
      r.frame_id = (c == 0) ? 8'h00 : 8'hff;
      r.radius = (c == 1) ? 8'h00 : r.radius;
      r.cluster = (c == 3) ? 16'h0000 : r.cluster;
      send(r);
      check_frame();
      $display("test corner %0d done", c);
    end
    send(rand_req());
    send(rand_req());
    check_frame();
    check_frame();
    $display("test back_to_back done");
    pace = 2'd2;
    r = rand_req();
    r.attr_count = 3'd4;
    send(r);
    repeat (60) @(negedge clk);
    check("stalled_busy", 64'(busy), 64'h1);
    check("stalled_valid", 64'(out_valid), 64'h1);
    pace = 2'd0;
    check_frame();
    $display("test buffer_full done");
    for (int t = 0; t < 24; t++) begin
      seed = xorshift(seed);
      pace = {1'b0, seed[0]};
      send(rand_req());
      check_frame();
    end
    $display("test random done");
    conclude();
  end
endmodule
